// [rtl/pipelined_burst_sram_port.sv]
// burst sram port: write buffer fifo and the pipelined port top
`include "sram_port_consts.svh"

// ----------------------------------------------------------------
// write buffer fifo
// ----------------------------------------------------------------
module write_buffer_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = `WFIFO_DEPTH_DEF
) (
    // clock, synced reset, enable
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    input  wire logic             clk_en_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH);

    // all pointer state in one struct
    typedef struct packed
    {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0]   count;
    } fifo_state_t;

    fifo_state_t            st_q;   // registered state
    fifo_state_t            st_d;   // next state
    logic [WIDTH-1:0]       mem_q [DEPTH];  // entry storage
    logic                   push;   // accepted write
    logic                   pop;    // accepted read

    // honest flags straight from the occupancy count
    assign in_ready_out  = (st_q.count != (PW+1)'(DEPTH));
    assign out_valid_out = (st_q.count != '0);
    assign out_data_out  = mem_q[st_q.rd_ptr];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    // pointer and count update
    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.wr_ptr = (st_q.wr_ptr == PW'(DEPTH-1)) ? '0 : st_q.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            st_d.rd_ptr = (st_q.rd_ptr == PW'(DEPTH-1)) ? '0 : st_q.rd_ptr + 1'b1;
        end
        // simultaneous push and pop leave the count alone
        if (push && !pop)
        begin
            st_d.count = st_q.count + 1'b1;
        end
        else if (pop && !push)
        begin
            st_d.count = st_q.count - 1'b1;
        end
    end

    // state register
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_q <= '0;
        end
        else if (clk_en_in)
        begin
            st_q <= st_d;
        end
    end

    // storage write, no reset needed on data
    always_ff @(posedge clock_in)
    begin
        if (clk_en_in && push)
        begin
            mem_q[st_q.wr_ptr] <= in_data_in;
        end
    end
endmodule : write_buffer_fifo

// ----------------------------------------------------------------
// pipelined burst sram port top
// ----------------------------------------------------------------
module pipelined_burst_sram_port
    import sram_port_pkg::*;
#(
    parameter int ADDR_W = `ADDR_WIDTH_DEF,  // 20 for the narrow variant
    parameter int DATA_W = `DATA_WIDTH_DEF,  // 18 for the narrow variant
    parameter int LANES  = `LANE_COUNT_DEF,  // 2 for the narrow variant
    parameter int WDEPTH = `WFIFO_DEPTH_DEF
) (
    // clock, reset, enable
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    input  wire logic              clk_en_in,
    // address and selects
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic              chip_select_primary_n_in,
    input  wire logic              depth_select_high_in,
    input  wire logic              depth_select_low_n_in,
    // burst control
    input  wire logic              processor_addr_strobe_n_in,
    input  wire logic              controller_addr_strobe_n_in,
    input  wire logic              burst_step_n_in,
    input  wire logic              burst_linear_in,
    // write control and data
    input  wire logic              global_write_n_in,
    input  wire logic              byte_write_enable_n_in,
    input  wire logic [LANES-1:0]  lane_write_select_n_in,
    input  wire logic [DATA_W-1:0] data_in,
    // unclocked controls
    input  wire logic              output_enable_n_in,
    input  wire logic              sleep_request_in,
    // data lines and status
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe_out,
    output logic                   write_stall_out
);
    import sram_port_pkg::*;

    localparam int LANE_W = DATA_W / LANES;
    localparam int CW     = `BURST_CNT_WIDTH;
    localparam int WORDS  = 1 << ADDR_W;
    localparam int FW     = ADDR_W + DATA_W + LANES;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [2:0]        mode_sync;  // three-stage strap sampler
        burst_order_t      order;      // accepted burst order
        logic [ADDR_W-1:0] addr;       // loaded address
        logic [CW-1:0]     start;      // burst start offset
        logic [CW-1:0]     cnt;        // burst step counter
        logic              sel;        // port selected
        logic              go;         // a word is issued this cycle
        logic              wr;         // captured cycle is a write
        logic [LANES-1:0]  lanes;      // captured lane mask
        logic [DATA_W-1:0] wdata;      // captured write data
        logic              arr_vld;    // array read issued last edge
        logic              out_vld;    // output register holds a read
        logic [DATA_W-1:0] dout;       // output data register
    } port_state_t;

    port_state_t        st_q;       // registered state
    port_state_t        st_d;       // next state
    logic [1:0]         rst_sync_q; // reset release synchroniser
    logic               rst_n;      // synced reset
    logic [DATA_W-1:0]  array_q [WORDS];  // storage array
    logic [DATA_W-1:0]  arr_rd_q;   // array read stage
    logic [CW-1:0]      burst_low;  // current burst offset
    logic [ADDR_W-1:0]  cur_addr;   // current word address
    logic               strobe;     // either address strobe active
    logic               cs_active;  // all chip selects active
    logic               wr_req;     // write wants the buffer
    logic               wr_ready;   // buffer has room
    logic               rd_go;      // read the array this cycle
    logic               drain_vld;  // buffered write waiting
    logic               drain_rdy;  // array free to take it
    logic [FW-1:0]      drain_word; // buffered addr, data, lanes

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // reset asserts at once but releases through two flops
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // burst address
    // ------------------------------------------------------------
    // offset wraps inside the aligned group of four words
    always_comb
    begin
        if (st_q.order == ORDER_LINEAR)
        begin
            burst_low = st_q.start + st_q.cnt;
        end
        else
        begin
            burst_low = st_q.start ^ st_q.cnt;
        end
    end
    assign cur_addr = {st_q.addr[ADDR_W-1:CW], burst_low};

    // decode of the pins in this cycle
    assign strobe    = !processor_addr_strobe_n_in | !controller_addr_strobe_n_in;
    assign cs_active = !chip_select_primary_n_in & depth_select_high_in
                     & !depth_select_low_n_in;

    // a captured write goes into the buffer; a read goes to the array
    assign wr_req = st_q.sel & st_q.wr;
    // only strobe and step edges issue a word, so an idle burst stays quiet
    assign rd_go  = st_q.sel & !st_q.wr & st_q.go;
    // a full buffer holds address, burst and write capture until a slot frees; the read pipe and strap sampler keep running
    assign write_stall_out = wr_req & !wr_ready;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        // strap sampler: change taken once stages two and three agree
        st_d.mode_sync = {st_q.mode_sync[1:0], burst_linear_in};
        if (st_q.mode_sync[2] == st_q.mode_sync[1])
        begin
            st_d.order = st_q.mode_sync[1] ? ORDER_LINEAR : ORDER_INTERLEAVED;
        end
        if (!write_stall_out)
        begin
            st_d.go = 1'b0;
            if (strobe)
            begin
                // new access: address and select loaded together
                st_d.addr  = addr_in;
                st_d.start = addr_in[`BURST_START_LSB +: CW];
                st_d.cnt   = '0;
                st_d.sel   = cs_active;
                st_d.go    = cs_active;
            end
            else if (!burst_step_n_in && st_q.sel)
            begin
                st_d.cnt = st_q.cnt + 1'b1;
                st_d.go  = 1'b1;
            end
            // write controls and data sampled every unstalled edge
            st_d.wr    = !global_write_n_in | !byte_write_enable_n_in;
            if (!global_write_n_in)
            begin
                st_d.lanes = '1;
            end
            else if (!byte_write_enable_n_in)
            begin
                st_d.lanes = ~lane_write_select_n_in;
            end
            else
            begin
                st_d.lanes = '0;
            end
            st_d.wdata = data_in;
            // read pipeline: array stage then output stage
            st_d.arr_vld = rd_go;
        end
        else
        begin
            // stalled: no new array read enters the pipe
            st_d.arr_vld = 1'b0;
        end
        st_d.out_vld = st_q.arr_vld;
        st_d.dout    = st_q.arr_vld ? arr_rd_q : st_q.dout;
    end

    // state register, frozen while the enable is low
    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else if (clk_en_in)
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------
    // drain pauses while asleep so no buffered write reaches the array
    assign drain_rdy = !sleep_request_in;

    write_buffer_fifo #(
        .WIDTH (FW),
        .DEPTH (WDEPTH)
    ) u_wbuf (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n),
        .clk_en_in     (clk_en_in),
        .in_valid_in   (wr_req),
        .in_ready_out  (wr_ready),
        .in_data_in    ({cur_addr, st_q.wdata, st_q.lanes}),
        .out_valid_out (drain_vld),
        .out_ready_in  (drain_rdy),
        .out_data_out  (drain_word)
    );

    // ------------------------------------------------------------
    // storage array
    // ------------------------------------------------------------
    // one process writes every lane so the array keeps a single driver;
    // parity bits ride in each lane
    always_ff @(posedge clock_in)
    begin
        if (clk_en_in && drain_vld && drain_rdy)
        begin
            for (int g = 0; g < LANES; g++)
            begin
                if (drain_word[g])
                begin
                    array_q[drain_word[FW-1 -: ADDR_W]][g*LANE_W +: LANE_W]
                        <= drain_word[LANES + g*LANE_W +: LANE_W];
                end
            end
        end
    end

    // read stage; a write drained last edge is already visible here
    always_ff @(posedge clock_in)
    begin
        if (clk_en_in && rd_go)
        begin
            arr_rd_q <= array_q[cur_addr];
        end
    end

    // ------------------------------------------------------------
    // data lines
    // ------------------------------------------------------------
    // enable is unclocked so the bus turns around at once
    assign data_out    = st_q.dout;
    assign data_oe_out = rst_n & st_q.out_vld & !output_enable_n_in
                       & !sleep_request_in;
endmodule : pipelined_burst_sram_port

// [common/sram_port_consts.svh]
// constants for the pipelined burst sram port
//
// Contract
// - all synchronous pins registered on rising edge
// - address and selects load only on strobe
// - later burst addresses step on burst_step
// - two-bit burst counter, four addresses per wrap; further burst_step pulses keep issuing words, wrapping to the first
// - writes registered together, then self-timed
// - byte lanes chosen by lane selects, byte_write_enable
// - global_write writes every lane
// - output enable and sleep act unclocked
// - interleaved or linear order, host matches it
// - first word after three clocks, then one
// - deselect ends within one clock
// - two independent address strobes, either starts
// - inputs and read data both registered
// - array 512K by 36 or 1M by 18
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

// ----------------------------------------------------------------
// array shape (wide variant by default)
// ----------------------------------------------------------------
`define ADDR_WIDTH_DEF   19
`define DATA_WIDTH_DEF   36
`define LANE_COUNT_DEF   4

// ----------------------------------------------------------------
// burst and buffering
// ----------------------------------------------------------------
`define BURST_CNT_WIDTH  2
`define BURST_START_LSB  0
`define WFIFO_DEPTH_DEF  32
`define READ_LATENCY     3

`endif

// [common/sram_port_pkg.sv]
// types shared by the sram port design
package sram_port_pkg;
    // burst address order selected by the mode strap
    typedef enum logic
    {
        ORDER_INTERLEAVED,
        ORDER_LINEAR
    } burst_order_t;
endpackage : sram_port_pkg

// [tb/pipelined_burst_sram_port_sva.sv]
// port checker for the pipelined burst sram port
module sram_port_checker #(
    parameter int DATA_W = 36,
    parameter int LANES  = 4
) (
    // clock, reset, enable
    input wire logic              clock_in,
    input wire logic              rst_n_in,
    input wire logic              clk_en_in,
    // bus pins
    input wire logic              chip_select_primary_n_in,
    input wire logic              depth_select_high_in,
    input wire logic              depth_select_low_n_in,
    input wire logic              processor_addr_strobe_n_in,
    input wire logic              controller_addr_strobe_n_in,
    input wire logic              burst_step_n_in,
    input wire logic              global_write_n_in,
    input wire logic              byte_write_enable_n_in,
    input wire logic [LANES-1:0]  lane_write_select_n_in,
    input wire logic              output_enable_n_in,
    input wire logic              sleep_request_in,
    // port outputs
    input wire logic [DATA_W-1:0] data_out,
    input wire logic              data_oe_out,
    input wire logic              write_stall_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic any_stb;  // either master strobes
    logic take;     // strobe accepted this edge
    logic sel;      // all three selects active
    logic wr;       // some lane is written
    logic quiet;    // async pins forbid driving

    assign any_stb = ~(processor_addr_strobe_n_in & controller_addr_strobe_n_in);
    assign take    = any_stb & clk_en_in & ~write_stall_out;
    assign sel     = ~chip_select_primary_n_in & depth_select_high_in & ~depth_select_low_n_in;
    assign wr      = ~global_write_n_in | (~byte_write_enable_n_in & ~&lane_write_select_n_in);
    assign quiet   = output_enable_n_in | sleep_request_in;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    oe_pin_gate_a: assert property (output_enable_n_in |-> !data_oe_out)
        else $error("lines driven with output enable off");
    sleep_gate_a: assert property (sleep_request_in |-> !data_oe_out)
        else $error("lines driven while asleep");
    first_word_a: assert property (take && sel && !wr |-> ##3 (data_oe_out || quiet))
        else $error("first read word late");
    next_word_a: assert property (take && sel && !wr ##1 (!burst_step_n_in && !any_stb)
        |-> ##3 (data_oe_out || quiet)) else $error("stepped word missing");
    step_hold_a: assert property (take && sel && !wr ##1 (burst_step_n_in && !any_stb)
        |-> ##3 !data_oe_out) else $error("word without burst step");
    deselect_end_a: assert property (take && !sel |-> ##3 !data_oe_out)
        else $error("lines driven after deselect");
    write_release_a: assert property (take && wr |-> ##3 !data_oe_out)
        else $error("lines driven for a write");
    data_hold_a: assert property (!quiet && $changed(data_out) |-> data_oe_out)
        else $error("read data changed without a word");
    stall_cause_a: assert property ($rose(write_stall_out) |-> $past(sleep_request_in))
        else $error("buffer filled while draining");

    read_seen_c: cover property (take && sel && !wr ##3 data_oe_out);
    write_seen_c: cover property (take && wr);
    stall_seen_c: cover property ($rose(write_stall_out));
endmodule : sram_port_checker

bind pipelined_burst_sram_port sram_port_checker #(.DATA_W(DATA_W), .LANES(LANES)) u_checker (.*);

// [tb/burst_host_model.sv]
// host model: drives the synchronous bus and collects read words
module burst_host_model #(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 36,
    parameter int LANES  = 4
) (
    // clock, and answers from the port
    input  wire logic              clock_in,
    input  wire logic [DATA_W-1:0] data_out,
    input  wire logic              data_oe_out,
    input  wire logic              write_stall_out,
    // bus driven by the host, grouped to keep the model short
    output logic [ADDR_W-1:0]      addr_in,
    output logic [DATA_W-1:0]      data_in,
    output logic [LANES-1:0]       lane_write_select_n_in,
    output logic chip_select_primary_n_in, depth_select_high_in, depth_select_low_n_in,
    output logic processor_addr_strobe_n_in, controller_addr_strobe_n_in, burst_step_n_in,
    output logic burst_linear_in, global_write_n_in, byte_write_enable_n_in,
    output logic output_enable_n_in, sleep_request_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DATA_W-1:0] seen_q[$];  // words seen while the port drove the lines

    // idle: strobes and writes off, selects on, linear order, outputs enabled
    initial
    begin
        {addr_in, data_in, lane_write_select_n_in} = '1;
        {chip_select_primary_n_in, depth_select_high_in, depth_select_low_n_in} = 3'h2;
        {processor_addr_strobe_n_in, controller_addr_strobe_n_in, burst_step_n_in} = 3'h7;
        {burst_linear_in, global_write_n_in, byte_write_enable_n_in} = 3'h7;
        {output_enable_n_in, sleep_request_in} = 2'h0;
    end

    // take each word at the falling edge, where it has settled
    always @(negedge clock_in)
        if (data_oe_out === 1'b1)
            seen_q.push_back(data_out);

    // one strobed cycle; pins held while the buffer refuses, then inverted
    // so that a stale address or data word can never pass for a fresh one
    task automatic access(input logic [ADDR_W-1:0] a, input logic proc, input logic sel,
                          input logic gw_n, input logic [LANES-1:0] ln_n,
                          input logic [DATA_W-1:0] d);
        logic stalled;
        int   n;
        @(negedge clock_in);
        {addr_in, data_in, global_write_n_in, chip_select_primary_n_in} = {a, d, gw_n, ~sel};
        {byte_write_enable_n_in, lane_write_select_n_in} = {&ln_n, ln_n};
        {processor_addr_strobe_n_in, controller_addr_strobe_n_in} = {~proc, proc};
        n = 0;
        do
        begin
            stalled = write_stall_out;
            @(negedge clock_in);
            n++;
        end while (stalled && n < 200);
        {processor_addr_strobe_n_in, controller_addr_strobe_n_in} = 2'h3;
        {global_write_n_in, byte_write_enable_n_in, lane_write_select_n_in} = '1;
        {addr_in, data_in, chip_select_primary_n_in} = {~a, ~d, 1'b0};
    endtask : access

    // read burst by the controller strobe, gap idle cycles before each step
    task automatic read_burst(input logic [ADDR_W-1:0] a, input logic sel, input int gap);
        access(a, 1'b0, sel, 1'b1, '1, '0);
        repeat (3)
        begin
            repeat (gap) @(negedge clock_in);
            burst_step_n_in = 1'b0;
            @(negedge clock_in);
            if (gap != 0)
                burst_step_n_in = 1'b1;
        end
        burst_step_n_in = 1'b1;
        repeat (4) @(negedge clock_in);
    endtask : read_burst
endmodule : burst_host_model

// [tb/pipelined_burst_sram_port_bench.sv]
// self-checking bench for the pipelined burst sram port
`include "sram_port_consts.svh"
module pipelined_burst_sram_port_bench
    import sram_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int AW = `ADDR_WIDTH_DEF;
    localparam int DW = `DATA_WIDTH_DEF;
    localparam int LN = `LANE_COUNT_DEF;

    logic clock_in = 1'b0, rst_n_in = 1'b0, clk_en_in = 1'b1;
    logic [AW-1:0] addr_in;
    logic [DW-1:0] data_in, data_out;
    logic [LN-1:0] lane_write_select_n_in;
    logic chip_select_primary_n_in, depth_select_high_in, depth_select_low_n_in;
    logic processor_addr_strobe_n_in, controller_addr_strobe_n_in, burst_step_n_in;
    logic burst_linear_in, global_write_n_in, byte_write_enable_n_in;
    logic output_enable_n_in, sleep_request_in, data_oe_out, write_stall_out;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [DW-1:0] shadow [int];  // expected array contents

    pipelined_burst_sram_port u_dut (.*);
    burst_host_model #(.ADDR_W(AW), .DATA_W(DW), .LANES(LN)) u_host (.*);

    initial
        forever #5 clock_in = ~clock_in;

    task automatic compare(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : compare

    // write one word; odd addresses use the processor strobe
    task automatic put(input int a, input logic gw_n, input logic [LN-1:0] ln_n,
                       input logic [DW-1:0] d);
        u_host.access(AW'(a), a[0], 1'b1, gw_n, ln_n, d);
        for (int g = 0; g < LN; g++)
            if (!gw_n || !ln_n[g])
                shadow[a][9*g +: 9] = d[9*g +: 9];
    endtask : put

    // read a burst and judge count and order of the words
    task automatic get(input int a, input int gap, input logic lin, input logic sel, input int n);
        int w;
        u_host.seen_q.delete();
        u_host.read_burst(AW'(a), sel, gap);
        compare("word count", DW'(n), DW'(u_host.seen_q.size()));
        foreach (u_host.seen_q[k])
        begin
            w = lin ? (a & ~3) | ((a + k) & 3) : a ^ k;
            compare("read word", shadow[w], u_host.seen_q[k]);
        end
    endtask : get

    task automatic t_orders();
        for (int i = 0; i < 8; i++)
            put(16 + i, 1'b0, '1, DW'(36'h123456789 * (i + 1)));
        for (int m = 0; m < 2; m++)
        begin
            u_host.burst_linear_in = m ? ORDER_INTERLEAVED : ORDER_LINEAR;
            repeat (5) @(negedge clock_in);
            get(17, 0, m == 0, 1'b1, 4);
            get(22, 2, m == 0, 1'b1, 4);
        end
        $display("test orders done");
    endtask : t_orders

    // one lane, two lanes, all lanes, then global write over stray lane selects
    task automatic t_lanes();
        logic [LN-1:0] mk [4] = '{4'hE, 4'hC, 4'h0, 4'h5};
        for (int i = 0; i < 4; i++)
        begin
            put(40 + i, 1'b0, '1, '1);
            put(40 + i, i < 3, mk[i], 36'h0A5A5A5A5 ^ DW'(i));
        end
        get(40, 0, 1'b1, 1'b1, 4);
        $display("test lanes done");
    endtask : t_lanes

    // output enable off, asleep, deselected: no word may reach the lines
    task automatic t_quiet();
        for (int c = 0; c < 3; c++)
        begin
            u_host.output_enable_n_in = (c == 0);
            u_host.sleep_request_in = (c == 1);
            get(40, 0, 1'b1, c != 2, 0);
        end
        u_host.sleep_request_in = 1'b0;
        get(40, 0, 1'b1, 1'b1, 4);
        $display("test quiet done");
    endtask : t_quiet

    // sleep stalls the drain: fill the buffer to refusal, then let it empty
    task automatic t_fill();
        u_host.sleep_request_in = 1'b1;
        for (int i = 0; i < 32; i++)
        begin
            if (i == 31)
                compare("stall", '0, DW'(write_stall_out));
            put(64 + i, 1'b0, '1, DW'(i) ^ 36'hF0F0F0F0F);
        end
        // the 33rd write finds the buffer full and raises write_stall_out
        fork
            put(96, 1'b0, '1, '0);
            begin
                repeat (2) @(negedge clock_in);
                compare("stall", DW'(1), DW'(write_stall_out));
                repeat (3) @(negedge clock_in);
                u_host.sleep_request_in = 1'b0;
            end
        join
        repeat (40) @(negedge clock_in);
        compare("stall", '0, DW'(write_stall_out));
        for (int i = 97; i < 100; i++)
            put(i, 1'b0, '1, DW'(i));
        for (int g = 64; g < 100; g += 4)
            get(g, 0, 1'b1, 1'b1, 4);
        $display("test fill done");
    endtask : t_fill

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // watchdog: the tests need about three and a half microseconds
    initial
    begin
        #50000;
        n_mismatch++;
        conclude();
    end

    initial
    begin
        repeat (6) @(negedge clock_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clock_in);
        t_orders();
        t_lanes();
        t_quiet();
        t_fill();
        conclude();
    end
endmodule : pipelined_burst_sram_port_bench
